// File: rtl/refsw_pkg.sv
package refsw_pkg;

    // register byte offsets
    localparam logic [5:0]  OFF_CTRL      = 6'h00;
    localparam logic [5:0]  OFF_CRYSTAL_LOAD_TRIM      = 6'h04;
    localparam logic [5:0]  OFF_PLL_ZERO      = 6'h08;
    localparam logic [5:0]  OFF_PLL1      = 6'h0C;
    localparam logic [5:0]  OFF_PLL2      = 6'h10;
    localparam logic [5:0]  OFF_PLL_THREE      = 6'h14;
    localparam logic [5:0]  OFF_STATUS    = 6'h18;
    localparam logic [5:0]  OFF_MULT      = 6'h1C;

    // register file indices (byte offset / 4)
    localparam logic [2:0]  IDX_CTRL      = 3'h0;
    localparam logic [2:0]  IDX_CRYSTAL_LOAD_TRIM      = 3'h1;
    localparam logic [2:0]  IDX_PLL_ZERO      = 3'h2;
    localparam logic [2:0]  IDX_STATUS    = 3'h6;
    localparam logic [2:0]  IDX_MULT      = 3'h7;
    localparam int          NUM_RW        = 6;

    // field positions
    localparam int          CTRL_PSEL     = 0;
    localparam int          CTRL_MODE_LO  = 1;
    localparam int          CTRL_MODE_HI  = 2;
    localparam int          CRYSTAL_LOAD_TRIM_TRIM_LO  = 0;
    localparam int          CRYSTAL_LOAD_TRIM_TRIM_HI  = 4;
    localparam int          CRYSTAL_LOAD_TRIM_DRV_LO   = 8;
    localparam int          CRYSTAL_LOAD_TRIM_DRV_HI   = 9;
    localparam int          PLL_D_LO      = 0;
    localparam int          PLL_D_HI      = 6;
    localparam int          PLL_N_LO      = 8;
    localparam int          PLL_N_HI      = 19;
    localparam int          PLL_A_LO      = 24;
    localparam int          PLL_A_HI      = 27;

    // writable bit masks
    localparam logic [31:0] MASK_CTRL     = 32'h0000_0007;
    localparam logic [31:0] MASK_CRYSTAL_LOAD_TRIM     = 32'h0000_031F;
    localparam logic [31:0] MASK_PLL_ZERO     = 32'h0F0F_FF7F;
    localparam logic [31:0] MASK_PLLX     = 32'h000F_FF7F;

    // reset values
    localparam logic [31:0] RST_CTRL      = 32'h0000_0000;
    localparam logic [31:0] RST_CRYSTAL_LOAD_TRIM      = 32'h0000_0300;
    localparam logic [31:0] RST_PLL       = 32'h0000_0101;
    localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;

    // loss detection, load capacitance (units of 0.125 pF) and pll divider constants
    localparam logic [1:0]  LOSS_COUNT    = 2'h2;
    localparam logic [5:0]  LOAD_BASE     = 6'h1C;
    localparam logic [6:0]  PLL_D_OFF     = 7'h00;
    localparam logic [6:0]  PLL_THREE_D_MIN    = 7'h03;
    localparam logic [3:0]  PLL_ZERO_A_ZERO   = 4'h0;

    typedef enum logic [1:0] {
        SW_RUN  = 2'b00,
        SW_PARK = 2'b01,
        SW_SWAP = 2'b11
    } sw_state_t;

endpackage

// File: rtl/reference_clock_switchover.sv
// Contract
// - pre-divider zero powers down pll zero, one or two
// - pll zero multiplier is 2N+A+1 for A nonzero, else 2N
// - primary-source bit 0 picks crystal input, 1 picks auxiliary input
// - mode field upper bit clear means manual switchover
// - in manual mode the select pin picks primary or secondary
// - manual source change is glitch free on the output
// - switching is asynchronous; raw routing could give narrow pulses
// - auto mode moves to secondary after two secondary cycles without primary
// - auto mode reverts to primary when it resumes
// - auto failover only when crystal input is primary
// - load capacitance is base plus trim times fixed step
module reference_clock_switchover (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // reference pins
    input  wire logic        crystalOrRefInput,
    input  wire logic        auxiliaryClockInput,
    input  wire logic        inputSelectPin,
    // to the plls
    output logic             refClkOut,
    output logic             auxSelected,
    output logic             onSecondary,
    output logic             primaryLost,
    output logic      [2:0]  pllPowerDown,
    output logic      [13:0] pll0Mult,
    output logic      [5:0]  loadCapSteps,
    output logic      [1:0]  crystalDriveStrength
);

    function automatic logic [31:0] mergeWrite(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] laneMask;
        laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
        return (old & ~laneMask) | (wd & laneMask);
    endfunction

    function automatic logic [13:0] pll0Multiplier(input logic [11:0] n, input logic [3:0] a);
        logic [13:0] twiceN;
        twiceN = {1'b0, n, 1'b0};
        if (a == refsw_pkg::PLL_ZERO_A_ZERO)
            return twiceN;
        return twiceN + {10'h000, a} + 14'h0001;
    endfunction

    // register file
    logic [31:0]              regs_q [refsw_pkg::NUM_RW];
    logic [31:0]              readdata_q;
    logic                     waitrequest_q;

    // reference path
    logic                     in0_q, in0Prev_q, in1_q, in1Prev_q, selPin_q;
    logic [1:0]               lossCnt_q;
    refsw_pkg::sw_state_t     state_q;
    logic                     curInput_q, target_q, refClk_q;
    logic                     onSecondary_q, primaryLost_q;
    logic [2:0]               pllPowerDown_q;
    logic [13:0]              pll0Mult_q;
    logic [5:0]               loadCapSteps_q;
    logic [1:0]               drive_q;

    // bus decode
    wire logic [2:0]  regIdx   = address[4:2];
    wire logic        aligned  = (address[1:0] == 2'b00) && !address[5];
    wire logic        rwHit    = aligned && (int'(regIdx) < refsw_pkg::NUM_RW);
    wire logic        wrAccept = write && !waitrequest_q && rwHit;
    wire logic        rdStart  = read && waitrequest_q;

    // control fields
    wire logic        psel      = regs_q[refsw_pkg::IDX_CTRL][refsw_pkg::CTRL_PSEL];
    wire logic        autoMode  = regs_q[refsw_pkg::IDX_CTRL][refsw_pkg::CTRL_MODE_HI];
    wire logic [31:0] xtalReg   = regs_q[refsw_pkg::IDX_CRYSTAL_LOAD_TRIM];
    wire logic [31:0] pll0Reg   = regs_q[refsw_pkg::IDX_PLL_ZERO];
    wire logic [4:0]  trim      = xtalReg[refsw_pkg::CRYSTAL_LOAD_TRIM_TRIM_HI:refsw_pkg::CRYSTAL_LOAD_TRIM_TRIM_LO];
    wire logic [6:0]  pll0D     = pll0Reg[refsw_pkg::PLL_D_HI:refsw_pkg::PLL_D_LO];
    wire logic [11:0] pll0N     = pll0Reg[refsw_pkg::PLL_N_HI:refsw_pkg::PLL_N_LO];
    wire logic [3:0]  pll0A     = pll0Reg[refsw_pkg::PLL_A_HI:refsw_pkg::PLL_A_LO];
    wire logic [6:0]  pll3D     = regs_q[5][refsw_pkg::PLL_D_HI:refsw_pkg::PLL_D_LO];
    wire logic        pll3Bad   = pll3D < refsw_pkg::PLL_THREE_D_MIN;

    // clock roles: input 0 is crystal/ref, input 1 is auxiliary
    wire logic        primS     = psel ? in1_q : in0_q;
    wire logic        secS      = psel ? in0_q : in1_q;
    wire logic        primRise  = psel ? (in1_q && !in1Prev_q) : (in0_q && !in0Prev_q);
    wire logic        secRise   = psel ? (in0_q && !in0Prev_q) : (in1_q && !in1Prev_q);
    wire logic        primLost  = lossCnt_q == refsw_pkg::LOSS_COUNT;
    // failover only with crystal/ref as primary; other assignment stays put
    wire logic        autoSec   = primLost && !psel;
    wire logic        wantSec   = autoMode ? autoSec : selPin_q;
    wire logic        wantInput = psel ^ wantSec;
    wire logic        curS      = curInput_q ? in1_q : in0_q;
    wire logic        targetS   = target_q ? in1_q : in0_q;
    // gate holds a running high phase to its end, then stays low until the new source is low
    wire logic        gateOpen  = (state_q == refsw_pkg::SW_RUN) ||
                                  (state_q == refsw_pkg::SW_PARK && refClk_q);

    logic [31:0] rdMux;
    always_comb
    begin
        if (!aligned)
            rdMux = refsw_pkg::RD_UNMAPPED;
        else if (regIdx == refsw_pkg::IDX_STATUS)
            rdMux = {25'h000_0000, pll3Bad, pllPowerDown_q, curInput_q, primaryLost_q,
                     onSecondary_q};
        else if (regIdx == refsw_pkg::IDX_MULT)
            rdMux = {10'h000, loadCapSteps_q, 2'b00, pll0Mult_q};
        else
            rdMux = regs_q[regIdx];
    end

    // one wait cycle on every access, then a single-cycle accept
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            waitrequest_q <= 1'b1;
            readdata_q    <= refsw_pkg::RD_UNMAPPED;
        end
        else
        begin
            waitrequest_q <= !((read || write) && waitrequest_q);
            if (rdStart)
                readdata_q <= rdMux;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            regs_q[0] <= refsw_pkg::RST_CTRL;
            regs_q[1] <= refsw_pkg::RST_CRYSTAL_LOAD_TRIM;
            for (int i = 2; i < refsw_pkg::NUM_RW; i++)
                regs_q[i] <= refsw_pkg::RST_PLL;
        end
        else if (wrAccept)
        begin
            if (regIdx == refsw_pkg::IDX_CTRL)
                regs_q[regIdx] <= mergeWrite(regs_q[regIdx], writedata, byteenable,
                                             refsw_pkg::MASK_CTRL);
            else if (regIdx == refsw_pkg::IDX_CRYSTAL_LOAD_TRIM)
                regs_q[regIdx] <= mergeWrite(regs_q[regIdx], writedata, byteenable,
                                             refsw_pkg::MASK_CRYSTAL_LOAD_TRIM);
            else if (regIdx == refsw_pkg::IDX_PLL_ZERO)
                regs_q[regIdx] <= mergeWrite(regs_q[regIdx], writedata, byteenable,
                                             refsw_pkg::MASK_PLL_ZERO);
            else
                regs_q[regIdx] <= mergeWrite(regs_q[regIdx], writedata, byteenable,
                                             refsw_pkg::MASK_PLLX);
        end
    end

    // pll settings
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pllPowerDown_q <= 3'h0;
            pll0Mult_q     <= 14'h0000;
            loadCapSteps_q <= refsw_pkg::LOAD_BASE;
            drive_q        <= refsw_pkg::RST_CRYSTAL_LOAD_TRIM[refsw_pkg::CRYSTAL_LOAD_TRIM_DRV_HI:refsw_pkg::CRYSTAL_LOAD_TRIM_DRV_LO];
        end
        else
        begin
            for (int p = 0; p < 3; p++)
                pllPowerDown_q[p] <= regs_q[p + 2][refsw_pkg::PLL_D_HI:refsw_pkg::PLL_D_LO]
                                     == refsw_pkg::PLL_D_OFF;
            pll0Mult_q     <= pll0Multiplier(pll0N, pll0A);
            loadCapSteps_q <= refsw_pkg::LOAD_BASE + {1'b0, trim};
            drive_q        <= xtalReg[refsw_pkg::CRYSTAL_LOAD_TRIM_DRV_HI:refsw_pkg::CRYSTAL_LOAD_TRIM_DRV_LO];
        end
    end

    // pin sampling; references must stay below half of mclk
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            in0_q     <= 1'b0;
            in0Prev_q <= 1'b0;
            in1_q     <= 1'b0;
            in1Prev_q <= 1'b0;
            selPin_q  <= 1'b0;
        end
        else
        begin
            in0_q     <= crystalOrRefInput;
            in0Prev_q <= in0_q;
            in1_q     <= auxiliaryClockInput;
            in1Prev_q <= in1_q;
            selPin_q  <= inputSelectPin;
        end
    end

    // loss counter stepped by secondary edges
    always_ff @(posedge mclk)
    begin
        if (rst)
            lossCnt_q <= 2'h0;
        else if (primRise)
            lossCnt_q <= 2'h0;
        else if (secRise && !primLost)
            lossCnt_q <= lossCnt_q + 2'h1;
    end

    // glitch-free source change: raw routing would cut pulses short
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_q    <= refsw_pkg::SW_RUN;
            curInput_q <= 1'b0;
            target_q   <= 1'b0;
        end
        else
        begin
            case (state_q)
                refsw_pkg::SW_RUN:
                    if (wantInput != curInput_q)
                    begin
                        target_q <= wantInput;
                        state_q  <= refsw_pkg::SW_PARK;
                    end
                refsw_pkg::SW_PARK:
                    if (!curS)
                        state_q <= refsw_pkg::SW_SWAP;
                refsw_pkg::SW_SWAP:
                    if (!targetS)
                    begin
                        curInput_q <= target_q;
                        state_q    <= refsw_pkg::SW_RUN;
                    end
                default:
                    state_q <= refsw_pkg::SW_RUN;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            refClk_q      <= 1'b0;
            onSecondary_q <= 1'b0;
            primaryLost_q <= 1'b0;
        end
        else
        begin
            refClk_q      <= gateOpen && curS;
            onSecondary_q <= curInput_q != psel;
            primaryLost_q <= primLost;
        end
    end

    assign readdata             = readdata_q;
    assign waitrequest          = waitrequest_q;
    assign refClkOut            = refClk_q;
    assign auxSelected          = curInput_q;
    assign onSecondary          = onSecondary_q;
    assign primaryLost          = primaryLost_q;
    assign pllPowerDown         = pllPowerDown_q;
    assign pll0Mult             = pll0Mult_q;
    assign loadCapSteps         = loadCapSteps_q;
    assign crystalDriveStrength = drive_q;

    property p_pwrdn;
        @(posedge mclk) disable iff (rst) (pll0D == refsw_pkg::PLL_D_OFF) |=> pllPowerDown_q[0];
    endproperty
    a_pwrdn: assert property (p_pwrdn) else $error("pll zero not powered down");

    property p_mult;
        @(posedge mclk) disable iff (rst)
            (pll0A == refsw_pkg::PLL_ZERO_A_ZERO) |=> (pll0Mult_q == {1'b0, $past(pll0N), 1'b0});
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier wrong for zero fraction");

    property p_manual;
        @(posedge mclk) disable iff (rst)
            (!autoMode && target_q == curInput_q && curInput_q != (psel ^ selPin_q))
            |=> target_q != curInput_q;
    endproperty
    a_manual: assert property (p_manual) else $error("manual selection wrong");

    property p_nofail;
        @(posedge mclk) disable iff (rst)
            (autoMode && psel && primLost && curInput_q && target_q) |=> curInput_q;
    endproperty
    a_nofail: assert property (p_nofail) else $error("failover with aux primary");

    property p_auto;
        @(posedge mclk) disable iff (rst)
            (autoMode && !psel && primLost && !curInput_q && !target_q) |=> target_q;
    endproperty
    a_auto: assert property (p_auto) else $error("automatic mode did not fail over");

    property p_glitch;
        @(posedge mclk) disable iff (rst)
            $rose(refClk_q) |-> ($past(state_q) == refsw_pkg::SW_RUN) && $past(curS);
    endproperty
    a_glitch: assert property (p_glitch) else $error("output rose outside run");

    property p_loss;
        @(posedge mclk) disable iff (rst)
            (secRise && !primRise && lossCnt_q == 2'h1) |=> ##1 primaryLost_q;
    endproperty
    a_loss: assert property (p_loss) else $error("loss not declared at two");

    property p_revert;
        @(posedge mclk) disable iff (rst) primRise |=> (lossCnt_q == 2'h0) ##1 !primaryLost_q;
    endproperty
    a_revert: assert property (p_revert) else $error("loss not cleared by primary");

    property p_load;
        @(posedge mclk) disable iff (rst)
            ##1 (loadCapSteps_q == refsw_pkg::LOAD_BASE + {1'b0, $past(trim)});
    endproperty
    a_load: assert property (p_load) else $error("load capacitance wrong");

    property p_ack;
        @(posedge mclk) disable iff (rst) $fell(waitrequest_q) |-> ##1 waitrequest_q;
    endproperty
    a_ack: assert property (p_ack) else $error("waitrequest low too long");

endmodule

// File: tb/ref_source_model.sv
module ref_source_model #(
    parameter int HALF = 5
) (
    // clock
    input  wire logic mclk,
    // controls from the bench
    input  wire logic runXtal,
    input  wire logic runAux,
    input  wire logic selReq,
    // reference pins
    output logic      crystalOrRefInput,
    output logic      auxiliaryClockInput,
    output logic      inputSelectPin
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt = 0;

    initial
    begin
        crystalOrRefInput = 1'b0;
        auxiliaryClockInput = 1'b0;
        inputSelectPin = 1'b0;
    end

    // equal rates keep the secondary never faster than the primary
    always @(posedge mclk)
    begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1)
        begin
            // a stopped source parks low, as a pull-down would leave it
            // an external clock, never a quartz crystal, drives the crystal input
            crystalOrRefInput <= runXtal ? ~crystalOrRefInput : 1'b0;
            auxiliaryClockInput <= runAux ? ~auxiliaryClockInput : 1'b0;
        end
        inputSelectPin <= selReq;
    end
endmodule

// File: tb/reference_clock_switchover_bench.sv
module reference_clock_switchover_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  address = 6'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        crystalOrRefInput;
    logic        auxiliaryClockInput;
    logic        inputSelectPin;
    logic        refClkOut;
    logic        auxSelected;
    logic        onSecondary;
    logic        primaryLost;
    logic [2:0]  pllPowerDown;
    logic [13:0] pll0Mult;
    logic [5:0]  loadCapSteps;
    logic [1:0]  crystalDriveStrength;
    logic        runXtal = 1'b1;
    logic        runAux = 1'b1;
    logic        selReq = 1'b0;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          comparisons = 0;

    always #2.5 mclk = ~mclk;

    reference_clock_switchover u_reference_clock_switchover (
        .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .crystalOrRefInput(crystalOrRefInput),
        .auxiliaryClockInput(auxiliaryClockInput), .inputSelectPin(inputSelectPin),
        .refClkOut(refClkOut), .auxSelected(auxSelected), .onSecondary(onSecondary),
        .primaryLost(primaryLost), .pllPowerDown(pllPowerDown), .pll0Mult(pll0Mult),
        .loadCapSteps(loadCapSteps), .crystalDriveStrength(crystalDriveStrength));

    ref_source_model u_ref_source_model (
        .mclk(mclk), .runXtal(runXtal), .runAux(runAux), .selReq(selReq),
        .crystalOrRefInput(crystalOrRefInput), .auxiliaryClockInput(auxiliaryClockInput),
        .inputSelectPin(inputSelectPin));

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int i;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        i = 0;
        do
        begin
            @(posedge mclk);
            i++;
        end
        while (waitrequest !== 1'b0 && i < 50);
        if (waitrequest !== 1'b0)
        begin
            chk("waitrequest timeout", 32'h0000_0000, 32'h0000_0001);
            conclude();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask

    // bounded wait for a routing state, judged when reached or at the bound
    task automatic wait_sel(input logic wantAux, input logic wantSec);
        int i;
        for (i = 0; i < 200 && {auxSelected, onSecondary} !== {wantAux, wantSec}; i++)
            @(posedge mclk);
        chk("aux and secondary", {30'h0, wantAux, wantSec}, {30'h0, auxSelected, onSecondary});
    endtask

    // refClkOut seen at an edge repeats the routed pin seen two edges before
    task automatic follow(input logic fromAux);
        logic [1:0] hist;
        int         bad;
        hist = 2'b00;
        bad = 0;
        for (int i = 0; i < 24; i++)
        begin
            @(posedge mclk);
            if (i >= 2 && refClkOut !== hist[1])
                bad++;
            hist = {hist[0], fromAux ? auxiliaryClockInput : crystalOrRefInput};
        end
        chk("reference follows pin", 32'h0000_0000, 32'(bad));
    endtask

    task automatic sc_reset();
        bus(1'b0, refsw_pkg::OFF_CTRL, 32'h0);
        chk("ctrl reset", refsw_pkg::RST_CTRL, q);
        bus(1'b0, refsw_pkg::OFF_CRYSTAL_LOAD_TRIM, 32'h0);
        chk("crystal_load_trim reset", refsw_pkg::RST_CRYSTAL_LOAD_TRIM, q);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b0, refsw_pkg::OFF_PLL_ZERO + 6'(4 * k), 32'h0);
            chk("pll reset", refsw_pkg::RST_PLL, q);
        end
        bus(1'b0, refsw_pkg::OFF_MULT, 32'h0);
        chk("mult reset", 32'h001C_0002, q);
        bus(1'b0, 6'h20, 32'h0);
        chk("unmapped", refsw_pkg::RD_UNMAPPED, q);
        bus(1'b0, refsw_pkg::OFF_STATUS, 32'h0);
        chk("status reset", 32'h0000_0040, q);
    endtask

    task automatic sc_dividers();
        for (int k = 0; k < 3; k++)
            bus(1'b1, refsw_pkg::OFF_PLL_ZERO + 6'(4 * k), 32'h0000_0100);
        bus(1'b1, refsw_pkg::OFF_PLL_THREE, 32'h0000_0103);
        repeat (4) @(posedge mclk);
        chk("power down", 32'h7, {29'h0, pllPowerDown});
        bus(1'b0, refsw_pkg::OFF_STATUS, 32'h0);
        chk("status dividers", 32'h7, {28'h0, q[6:3]});
        for (int k = 0; k < 3; k++)
            bus(1'b1, refsw_pkg::OFF_PLL_ZERO + 6'(4 * k), 32'h0000_0101);
        bus(1'b1, refsw_pkg::OFF_PLL_ZERO, 32'h0000_0501);
        repeat (4) @(posedge mclk);
        chk("power up", 32'h0, {29'h0, pllPowerDown});
        chk("mult a zero", 32'd10, {18'h0, pll0Mult});
        bus(1'b1, refsw_pkg::OFF_PLL_ZERO, 32'h0300_0501);
        repeat (4) @(posedge mclk);
        chk("mult a three", 32'd14, {18'h0, pll0Mult});
        bus(1'b1, refsw_pkg::OFF_PLL_ZERO, 32'h0F0F_FF01);
        bus(1'b1, refsw_pkg::OFF_CRYSTAL_LOAD_TRIM, 32'h0000_011F);
        repeat (4) @(posedge mclk);
        chk("mult top", 32'd8206, {18'h0, pll0Mult});
        chk("load cap", 32'd59, {26'h0, loadCapSteps});
        chk("drive", 32'd1, {30'h0, crystalDriveStrength});
        bus(1'b1, refsw_pkg::OFF_CRYSTAL_LOAD_TRIM, refsw_pkg::RST_CRYSTAL_LOAD_TRIM);
    endtask

    task automatic sc_manual();
        for (int m = 0; m < 2; m++)
        begin
            bus(1'b1, refsw_pkg::OFF_CTRL, 32'(m * 2));
            selReq <= 1'b0;
            wait_sel(1'b0, 1'b0);
            selReq <= 1'b1;
            wait_sel(1'b1, 1'b1);
            follow(1'b1);
            selReq <= 1'b0;
            wait_sel(1'b0, 1'b0);
            follow(1'b0);
        end
        bus(1'b1, refsw_pkg::OFF_CTRL, 32'h0000_0001);
        wait_sel(1'b1, 1'b0);
        selReq <= 1'b1;
        wait_sel(1'b0, 1'b1);
        selReq <= 1'b0;
        wait_sel(1'b1, 1'b0);
    endtask

    task automatic sc_auto();
        for (int m = 0; m < 2; m++)
        begin
            bus(1'b1, refsw_pkg::OFF_CTRL, 32'(4 + m * 2));
            wait_sel(1'b0, 1'b0);
            runXtal <= 1'b0;
            wait_sel(1'b1, 1'b1);
            chk("lost", 32'h1, {31'h0, primaryLost});
            runXtal <= 1'b1;
            wait_sel(1'b0, 1'b0);
        end
        bus(1'b1, refsw_pkg::OFF_CTRL, 32'h0000_0005);
        wait_sel(1'b1, 1'b0);
        runAux <= 1'b0;
        repeat (60) @(posedge mclk);
        chk("no failover", 32'h2, {30'h0, auxSelected, onSecondary});
        runAux <= 1'b1;
        bus(1'b1, refsw_pkg::OFF_CTRL, 32'h0);
        wait_sel(1'b0, 1'b0);
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        sc_reset();
        sc_dividers();
        sc_manual();
        sc_auto();
        conclude();
    end
endmodule
